/* File: pkg/ata_pkg.sv */
package ata_pkg;

  // Task-file offsets; offset 1 reads error, offset 7 reads status
  localparam logic [2:0] OFS_DATA     = 3'h0;
  localparam logic [2:0] OFS_FEATURE  = 3'h1;
  localparam logic [2:0] OFS_COUNT    = 3'h2;
  localparam logic [2:0] OFS_SECNUM   = 3'h3;
  localparam logic [2:0] OFS_CYL_LO   = 3'h4;
  localparam logic [2:0] OFS_CYL_HI   = 3'h5;
  localparam logic [2:0] OFS_DRVHEAD  = 3'h6;
  localparam logic [2:0] OFS_OPCODE   = 3'h7;

  // Opcodes handled here
  localparam logic [7:0] OP_WEAR      = 8'hF5;
  localparam logic [7:0] OP_WBUF      = 8'hE8;
  localparam logic [7:0] OP_LONG_A    = 8'h32;
  localparam logic [7:0] OP_LONG_B    = 8'h33;
  localparam logic [7:0] OP_WMULT     = 8'hC5;
  localparam logic [7:0] OP_SETMULT   = 8'hC6;

  // Sizes
  localparam logic [8:0] SECTOR_WORDS = 9'h100;
  localparam logic [8:0] MAX_SECTORS  = 9'h100;
  localparam logic [2:0] ECC_BYTES    = 3'h4;
  localparam logic [7:0] BLOCK_SIZE   = 8'h01;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  // Status and error bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_ABRT = 2;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int BSY_LIMIT_NS  = 400;
  localparam int BSY_MAX_CYC   = (BSY_LIMIT_NS / CLK_PERIOD_NS < 1) ? 1 : BSY_LIMIT_NS / CLK_PERIOD_NS;

  // Command phase, Gray coded along idle-accept-transfer-program
  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_ACCEPT  = 2'b01,
    PH_XFER    = 2'b11,
    PH_PROGRAM = 2'b10
  } phase_e;

  // Decoded command
  typedef enum logic [2:0] {
    CMD_NONE, CMD_WEAR, CMD_WBUF, CMD_LONG, CMD_WMULT, CMD_SETMULT, CMD_ABORT
  } cmd_e;

  // Task-file access from the host side
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tf_bus_s;

endpackage : ata_pkg

/* File: src/ata_write_command_executor.sv */
`timescale 1ns/10ps
module ata_write_command_executor (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire ata_pkg::tf_bus_s host_bus,
  input  wire logic             media_error,
  output logic [15:0]           rdata,
  output logic                  intrq,
  output logic                  media_valid,
  output logic [15:0]           media_wdata,
  output logic [15:0]           media_check,
  output logic [27:0]           media_lba
);
  import ata_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Write strobe aimed at one task-file offset
  function automatic logic tf_write(input tf_bus_s b, input logic [2:0] ofs);
    tf_write = b.wr && (b.addr == ofs);
  endfunction : tf_write

  // Linear sector address from the address bytes
  function automatic logic [27:0] pack_lba(input logic [7:0] dh, input logic [7:0] ch,
                                           input logic [7:0] cl, input logic [7:0] sn);
    pack_lba = {dh[3:0], ch, cl, sn};
  endfunction : pack_lba

  ////////////////////////////////////////////////////////////////////////////
  // State

  phase_e      phase;                   // Command phase
  cmd_e        cmd;                     // Command in progress
  logic [7:0]  sector_count_byte;       // Count, residual after error
  logic [7:0]  sector_number_byte;      // Address bits 7..0
  logic [7:0]  cylinder_low_byte;       // Address bits 15..8
  logic [7:0]  cylinder_high_byte;      // Address bits 23..16
  logic [7:0]  drive_head_select;       // Mode, drive, address bits 27..24
  logic [7:0]  error_byte;              // Error register
  logic        err_flag;                // Status error bit
  logic        mult_en;                 // Write-multiple allowed
  logic [8:0]  remaining;               // Sectors still to move
  logic [7:0]  blk_left;                // Sectors left in current block
  logic [8:0]  word_idx;                // Words received this sector
  logic [2:0]  ecc_cnt;                 // Check bytes received
  logic [8:0]  prog_idx;                // Words streamed to the media
  logic [15:0] sector_buf [0:255];      // Sector buffer

  // Combinational events
  logic        opcode_wr;               // Opcode taken while idle
  logic        data_wr;                 // Data-port write during transfer
  logic        xfer_done;               // Sector fully received
  logic        prog_last;               // Media write finished
  logic        sector_ok;               // Sector written cleanly
  logic        sector_bad;              // Media reported failure
  logic        more_sectors;            // Another sector follows
  logic        done_evt;                // Command complete
  logic        block_evt;               // New block begins
  logic [8:0]  count_req;               // Requested count, zero as 256
  cmd_e        decoded;                 // Opcode decode
  logic [27:0] lba_now;                 // Current address
  logic [7:0]  status_byte;             // Status as read

  ////////////////////////////////////////////////////////////////////////////
  // Decode and events

  assign opcode_wr = ce && (phase == PH_IDLE) && tf_write(host_bus, OFS_OPCODE);
  assign data_wr   = ce && (phase == PH_XFER) && tf_write(host_bus, OFS_DATA);
  // Word phase then byte phase for the long write
  assign xfer_done = (word_idx == SECTOR_WORDS) && ((cmd != CMD_LONG) || (ecc_cnt == ECC_BYTES));
  assign prog_last  = (phase == PH_PROGRAM) && (prog_idx == SECTOR_WORDS);
  assign sector_ok  = ce && prog_last && !media_error;
  assign sector_bad = ce && prog_last && media_error;
  // Long and buffer writes never go past one sector
  assign more_sectors = (cmd == CMD_WMULT) && (remaining > 9'h001);
  assign lba_now   = pack_lba(drive_head_select, cylinder_high_byte, cylinder_low_byte, sector_number_byte);
  assign count_req = (sector_count_byte == RESET_BYTE) ? MAX_SECTORS : {1'b0, sector_count_byte};

  // Completion: immediate commands, buffer fill, last sector or failure
  assign done_evt = ce && (((phase == PH_ACCEPT) && (cmd != CMD_WBUF) && (cmd != CMD_LONG) && (cmd != CMD_WMULT))
                        || ((phase == PH_XFER) && xfer_done && (cmd == CMD_WBUF))
                        || sector_bad || (sector_ok && !more_sectors));
  // Interrupt with DRQ only where a new block starts
  assign block_evt = sector_ok && more_sectors && (blk_left == 8'h01);

  // Opcode decode; write-multiple refused unless enabled
  always_comb begin
    case (host_bus.wdata[7:0])
      OP_WEAR:    decoded = CMD_WEAR;
      OP_WBUF:    decoded = CMD_WBUF;
      OP_LONG_A:  decoded = CMD_LONG;
      OP_LONG_B:  decoded = CMD_LONG;
      OP_WMULT:   decoded = mult_en ? CMD_WMULT : CMD_ABORT;
      OP_SETMULT: decoded = CMD_SETMULT;
      default:    decoded = CMD_ABORT;
    endcase
  end

  // Status: busy in accept and program, DRQ only in transfer
  always_comb begin
    status_byte         = 8'h00;
    status_byte[ST_BSY] = (phase == PH_ACCEPT) || (phase == PH_PROGRAM);
    status_byte[ST_RDY] = 1'b1;
    status_byte[ST_DSC] = 1'b1;
    status_byte[ST_DRQ] = (phase == PH_XFER);
    status_byte[ST_ERR] = err_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  // Phase, counters and command bookkeeping
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase     <= PH_IDLE;
      cmd       <= CMD_NONE;
      remaining <= 9'h000;
      blk_left  <= 8'h00;
      word_idx  <= 9'h000;
      ecc_cnt   <= 3'h0;
      prog_idx  <= 9'h000;
    end else if (ce) begin
      case (phase)
        PH_IDLE: begin
          // Busy from the very next edge, well inside the limit
          if (opcode_wr) begin
            phase     <= PH_ACCEPT;
            cmd       <= decoded;
            remaining <= count_req;
            blk_left  <= BLOCK_SIZE;
            word_idx  <= 9'h000;
            ecc_cnt   <= 3'h0;
          end
        end
        PH_ACCEPT: begin
          // Data commands open the buffer with no interrupt
          if ((cmd == CMD_WBUF) || (cmd == CMD_LONG) || (cmd == CMD_WMULT)) begin
            phase <= PH_XFER;
          end else begin
            phase <= PH_IDLE;
          end
        end
        PH_XFER: begin
          // Words fill the buffer, then the check bytes are counted
          if (data_wr && (word_idx != SECTOR_WORDS)) begin
            word_idx <= word_idx + 9'h001;
          end else if (data_wr && (cmd == CMD_LONG) && (ecc_cnt != ECC_BYTES)) begin
            ecc_cnt <= ecc_cnt + 3'h1;
          end
          if (xfer_done) begin
            phase    <= (cmd == CMD_WBUF) ? PH_IDLE : PH_PROGRAM;
            prog_idx <= 9'h000;
          end
        end
        PH_PROGRAM: begin
          if (!prog_last) begin
            prog_idx <= prog_idx + 9'h001;
          end else if (media_error) begin
            phase <= PH_IDLE;
          end else if (more_sectors) begin
            // Inside a block the host keeps going without a new DRQ check
            phase     <= PH_XFER;
            remaining <= remaining - 9'h001;
            word_idx  <= 9'h000;
            blk_left  <= (blk_left == 8'h01) ? BLOCK_SIZE : blk_left - 8'h01;
          end else begin
            phase     <= PH_IDLE;
            remaining <= remaining - 9'h001;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Multiple mode: zero disables, unsupported size aborts and disables
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mult_en <= 1'b0;
    end else if (ce && (phase == PH_ACCEPT) && (cmd == CMD_SETMULT)) begin
      mult_en <= (sector_count_byte == BLOCK_SIZE);
    end
  end

  // Error reporting; cleared as each command is accepted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      error_byte <= 8'h00;
      err_flag   <= 1'b0;
    end else if (ce) begin
      if (opcode_wr) begin
        error_byte <= 8'h00;
        err_flag   <= 1'b0;
      end else if ((phase == PH_ACCEPT) && ((cmd == CMD_ABORT) ||
                   ((cmd == CMD_SETMULT) && (sector_count_byte != RESET_BYTE) &&
                    (sector_count_byte != BLOCK_SIZE)))) begin
        error_byte[ER_ABRT] <= 1'b1;
        err_flag            <= 1'b1;
      end else if (sector_bad) begin
        error_byte[ER_UNC] <= 1'b1;
        err_flag           <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task file

  // Host writes only while idle; the engine updates count and address
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sector_count_byte  <= RESET_BYTE;
      sector_number_byte <= RESET_BYTE;
      cylinder_low_byte  <= RESET_BYTE;
      cylinder_high_byte <= RESET_BYTE;
      drive_head_select  <= RESET_BYTE;
    end else if (ce) begin
      if ((phase == PH_IDLE) && host_bus.wr) begin
        case (host_bus.addr)
          OFS_COUNT:   sector_count_byte  <= host_bus.wdata[7:0];
          OFS_SECNUM:  sector_number_byte <= host_bus.wdata[7:0];
          OFS_CYL_LO:  cylinder_low_byte  <= host_bus.wdata[7:0];
          OFS_CYL_HI:  cylinder_high_byte <= host_bus.wdata[7:0];
          OFS_DRVHEAD: drive_head_select  <= host_bus.wdata[7:0];
          default:     ;
        endcase
      end else if ((phase == PH_ACCEPT) && (cmd == CMD_WEAR)) begin
        sector_count_byte <= RESET_BYTE;
      end else if (sector_ok && (cmd == CMD_WMULT)) begin
        // A failed sector leaves both untouched, so they name it
        sector_count_byte  <= sector_count_byte - 8'h01;
        {drive_head_select[3:0], cylinder_high_byte, cylinder_low_byte, sector_number_byte}
          <= lba_now + 28'h000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sector buffer and media stream

  // Buffer write; extra bytes of the long write are dropped here
  always_ff @(posedge clk_sys) begin
    if (data_wr && (word_idx != SECTOR_WORDS)) begin
      sector_buf[word_idx[7:0]] <= host_bus.wdata;
    end
  end

  // Stream to the media with a locally computed check word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      media_valid <= 1'b0;
      media_wdata <= 16'h0000;
      media_check <= 16'h0000;
      media_lba   <= 28'h000_0000;
    end else if (ce) begin
      media_valid <= (phase == PH_PROGRAM) && !prog_last;
      if ((phase == PH_PROGRAM) && !prog_last) begin
        media_wdata <= sector_buf[prog_idx[7:0]];
        media_check <= (prog_idx == 9'h000) ? sector_buf[prog_idx[7:0]]
                                            : media_check ^ sector_buf[prog_idx[7:0]];
        media_lba   <= lba_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and read port

  // Status read clears the request; a new event in that cycle wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      intrq <= 1'b0;
    end else if (ce) begin
      if (done_evt || block_evt) begin
        intrq <= 1'b1;
      end else if (host_bus.rd && (host_bus.addr == OFS_OPCODE)) begin
        intrq <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; data port reads as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      if (host_bus.rd) begin
        case (host_bus.addr)
          OFS_FEATURE: rdata <= {8'h00, error_byte};
          OFS_COUNT:   rdata <= {8'h00, sector_count_byte};
          OFS_SECNUM:  rdata <= {8'h00, sector_number_byte};
          OFS_CYL_LO:  rdata <= {8'h00, cylinder_low_byte};
          OFS_CYL_HI:  rdata <= {8'h00, cylinder_high_byte};
          OFS_DRVHEAD: rdata <= {8'h00, drive_head_select};
          OFS_OPCODE:  rdata <= {8'h00, status_byte};
          default:     rdata <= 16'h0000;
        endcase
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int bsy_lim = BSY_MAX_CYC;

  sequence s_wmult_issued;
    opcode_wr && (host_bus.wdata[7:0] == OP_WMULT) && mult_en;
  endsequence

  sequence s_sector_accepted;
    ce && (phase == PH_PROGRAM) && prog_last && !media_error;
  endsequence

  a_bsy_after_wmult: assert property (@(posedge clk_sys) disable iff (rst)
    s_wmult_issued |-> ##[1:bsy_lim] status_byte[ST_BSY])
    else $error("busy late after write-multiple");

  a_wear_zero_cnt: assert property (@(posedge clk_sys) disable iff (rst)
    (opcode_wr && (host_bus.wdata[7:0] == OP_WEAR)) ##1 ce |-> ##1 (sector_count_byte == 8'h00))
    else $error("wear level count not zero");

  a_first_fill_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && (phase == PH_ACCEPT) && (cmd == CMD_WMULT) && !intrq) |=> (phase == PH_XFER) && !intrq)
    else $error("interrupt on first fill");

  a_long_one_sector: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && prog_last && (cmd == CMD_LONG)) |=> (phase == PH_IDLE))
    else $error("long write went on");

  a_mult_abort_err: assert property (@(posedge clk_sys) disable iff (rst)
    (opcode_wr && (host_bus.wdata[7:0] == OP_WMULT) && !mult_en) ##1 ce |=> error_byte[ER_ABRT] && err_flag)
    else $error("write-multiple not aborted");

  a_zero_disables: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && (phase == PH_ACCEPT) && (cmd == CMD_SETMULT) && (sector_count_byte == 8'h00)) |=> !mult_en)
    else $error("zero count left multiple enabled");

  a_count_zero_256: assert property (@(posedge clk_sys) disable iff (rst)
    (opcode_wr && (sector_count_byte == 8'h00)) |=> (remaining == 9'h100))
    else $error("zero count not 256");

  a_error_stops: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && prog_last && media_error) |=> (phase == PH_IDLE) && err_flag && $stable(sector_count_byte))
    else $error("error did not stop transfer");

  a_final_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (phase == PH_PROGRAM) |-> status_byte[ST_BSY] && !status_byte[ST_DRQ])
    else $error("busy or drq wrong while writing");

  a_block_start_irq: assert property (@(posedge clk_sys) disable iff (rst)
    (s_sector_accepted and (more_sectors && (blk_left == 8'h01))) |=> intrq && (phase == PH_XFER))
    else $error("no interrupt at block start");

  a_mid_block_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && (phase == PH_XFER) && (cmd == CMD_WMULT) && !intrq) |=> !intrq)
    else $error("interrupt inside block");

  a_residual_count: assert property (@(posedge clk_sys) disable iff (rst)
    (s_sector_accepted and (cmd == CMD_WMULT)) |=> (sector_count_byte == $past(sector_count_byte) - 8'h01))
    else $error("residual count wrong");

endmodule : ata_write_command_executor

/* File: test/host_model.sv */
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] rdata,
  output ata_pkg::tf_bus_s host_bus
);
  import ata_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus starts idle, no strobe
  initial host_bus = '0;

  // One write strobe; data inverted afterwards so stale data never looks live
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    host_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    host_bus <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr_reg

  // One read strobe; answer taken in the cycle after it only
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    host_bus <= '{addr: a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    host_bus.rd <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask : rd_reg

  // Task file first, opcode last, since the opcode starts execution
  task automatic issue(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] sn);
    wr_reg(OFS_COUNT, {8'h00, cnt});
    wr_reg(OFS_SECNUM, {8'h00, sn});
    wr_reg(OFS_CYL_LO, 16'h0000);
    wr_reg(OFS_CYL_HI, 16'h0000);
    wr_reg(OFS_DRVHEAD, 16'h00E0);
    wr_reg(OFS_OPCODE, {8'h00, op});
  endtask : issue

  // Whole sector of words, no status check between words
  task automatic sector(input logic [15:0] base);
    for (int i = 0; i < 256; i++) wr_reg(OFS_DATA, base + 16'(i));
  endtask : sector

  // Check bytes travel on the low lane only
  task automatic bytes4();
    for (int i = 0; i < 4; i++) wr_reg(OFS_DATA, {8'h00, 8'hE0 + 8'(i)});
  endtask : bytes4
endmodule : host_model

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
  import ata_pkg::*;
  logic        clk_sys, rst, ce, media_error, intrq, media_valid, err_arm, irq_flag;
  logic [15:0] rdata, media_wdata, media_check, v, wxor;
  logic [27:0] media_lba;
  tf_bus_s     host_bus;
  int          bad_count, comparisons, mcount;

  ata_write_command_executor ata_write_command_executor_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .host_bus(host_bus), .media_error(media_error), .rdata(rdata), .intrq(intrq),
    .media_valid(media_valid), .media_wdata(media_wdata), .media_check(media_check), .media_lba(media_lba));
  host_model host_model_inst (.clk_sys(clk_sys), .rdata(rdata), .host_bus(host_bus));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Media watcher; failure injected well inside the second sector only
  always @(posedge clk_sys) begin
    if (media_valid === 1'b1) mcount <= mcount + 1;
    if (media_valid === 1'b1) wxor <= wxor ^ media_wdata;
    if (intrq === 1'b1) irq_flag <= 1'b1;
    media_error <= err_arm && (mcount >= 300);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Poll status until masked value matches; bounded
  task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
    for (int i = 0; i < 3000; i++) begin
      host_model_inst.rd_reg(OFS_OPCODE, v);
      if ((v[7:0] & mask) === val) return;
    end
    bad_count++;
    give_verdict();
  endtask : wait_stat

  // Expected device check: XOR of the streamed words
  function automatic logic [15:0] sec_xor(input logic [15:0] base);
    logic [15:0] x;
    x = 16'h0000;
    for (int i = 0; i < 256; i++) x ^= base + 16'(i);
    return x;
  endfunction : sec_xor

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_wear();
    host_model_inst.issue(OP_WEAR, 8'h07, 8'h11);
    wait_stat(8'h88, 8'h00);
    check(v, 16'h0050);
    host_model_inst.rd_reg(OFS_COUNT, v);
    check(v, 16'h0000);
  endtask : t_wear

  // Any refused command ends idle with the abort bit set
  task automatic t_abort(input logic [7:0] op, input logic [7:0] cnt);
    host_model_inst.issue(op, cnt, 8'h01);
    wait_stat(8'h80, 8'h00);
    check(v, 16'h0051);
    host_model_inst.rd_reg(OFS_FEATURE, v);
    check({15'h0000, v[ER_ABRT]}, 16'h0001);
  endtask : t_abort

  // Sector-write style command; secs sectors are sent before the end
  task automatic t_write(input logic [7:0] op, input logic [7:0] cnt, input int secs, input logic err);
    mcount = 0;
    wxor = 16'h0000;
    err_arm = err;
    host_model_inst.issue(op, cnt, 8'h40);
    for (int s = 0; s < secs; s++) begin
      irq_flag = 1'b0;
      wait_stat(8'h88, 8'h08);
      check({15'h0000, irq_flag}, (s == 0) ? 16'h0000 : 16'h0001);
      host_model_inst.sector(16'h1230 + 16'(s));
      if (op == OP_LONG_A || op == OP_LONG_B) host_model_inst.bytes4();
    end
    irq_flag = 1'b0;
    wait_stat(8'h88, 8'h00);
    check({15'h0000, irq_flag}, 16'h0001);
    check(v, err ? 16'h0051 : 16'h0050);
    check(16'(mcount), (op == OP_WBUF) ? 16'h0000 : 16'(256 * secs));
    err_arm = 1'b0;
  endtask : t_write

  // Idle after reset; a write while the enable is low is lost
  task automatic t_idle_freeze();
    host_model_inst.rd_reg(OFS_OPCODE, v);
    check(v, 16'h0050);
    ce <= 1'b0;
    host_model_inst.wr_reg(OFS_COUNT, 16'h005A);
    ce <= 1'b1;
    host_model_inst.rd_reg(OFS_COUNT, v);
    check(v, 16'h0000);
  endtask : t_idle_freeze

  // Both long-write opcodes; only the words reach the media
  task automatic t_long();
    for (int k = 0; k < 2; k++) begin
      t_write((k == 0) ? OP_LONG_A : OP_LONG_B, 8'h01, 1, 1'b0);
      check(media_check, sec_xor(16'h1230));
      check(wxor, sec_xor(16'h1230));
    end
  endtask : t_long

  // Multiple-mode setup; one enables, zero disables
  task automatic t_setmult(input logic [7:0] cnt);
    host_model_inst.issue(OP_SETMULT, cnt, 8'h00);
    wait_stat(8'h88, 8'h00);
    check(v, 16'h0050);
  endtask : t_setmult

  // Two sectors in blocks of one; address steps per sector
  task automatic t_wmult2();
    t_write(OP_WMULT, 8'h02, 2, 1'b0);
    check(media_lba[15:0], 16'h0041);
    check(media_check, sec_xor(16'h1231));
    check(wxor, sec_xor(16'h1230) ^ sec_xor(16'h1231));
  endtask : t_wmult2

  // Failure in the second of 256 sectors; task file names it
  task automatic t_wmult_err();
    t_write(OP_WMULT, 8'h00, 2, 1'b1);
    host_model_inst.rd_reg(OFS_COUNT, v);
    check(v, 16'h00FF);
    host_model_inst.rd_reg(OFS_SECNUM, v);
    check(v, 16'h0041);
    host_model_inst.rd_reg(OFS_FEATURE, v);
    check({15'h0000, v[ER_UNC]}, 16'h0001);
  endtask : t_wmult_err

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    media_error = 1'b0;
    err_arm = 1'b0;
    irq_flag = 1'b0;
    mcount = 0;
    wxor = 16'h0000;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_idle_freeze();
    t_wear();
    t_abort(OP_WMULT, 8'h01);
    t_abort(OP_SETMULT, 8'h02);
    t_write(OP_WBUF, 8'h01, 1, 1'b0);
    t_long();
    t_setmult(8'h01);
    t_wmult2();
    t_wmult_err();
    t_setmult(8'h00);
    t_abort(OP_WMULT, 8'h01);
    give_verdict();
  end
endmodule : tb
